// ### pgs_frame.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Serial modes 0,0 (clock idles low) and 1,1 (clock idles high) are both accepted.
// R2: Input data is sampled on rising serial clock edges and output data changes on falling ones.
// R3: Phase zero samples on the first edge after select, phase one on the second edge.
// R4: A frame whose clock count is not a nonzero multiple of 16 is ignored and changes nothing.
// R5: Every chip-select assertion restarts the bit counter so a short frame resynchronises.
// R6: A received frame is committed only at chip-select rise and only if it passed the length check.
// R7: The serial output is released while chip select is high and driven only while it is low.
// R8: Shutdown-enter sets shutdown; shutdown-exit clears it keeping the config, and any valid write clears it while loading new config.
// R9: Reset clears gain and channel to zero, which is gain one and channel zero.
// R10: A no-operation command leaves configuration and shutdown unchanged.
// R11: After a valid read frame the 16-bit register is shifted out MSB first in the next frame.
module pgs_frame
   import pgs_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic din_pin,
   output logic dout_o,
   output logic dout_oe_n,
   output pgs_cfg_t cfg_r
);
   pgs_pins_t pins_s;
   logic sclk_d_r;
   logic cs_n_d_r;
   logic [CNT_W-1:0] bit_cnt_r;
   logic any_clk_r;
   logic [FRAME_BITS-1:0] rx_r;
   logic [FRAME_BITS-1:0] tx_r;
   logic din_cap_r;
   logic read_pend_r;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic len_ok;
   pgs_kind_t kind;
   pgs_pins_t pins_a;

   function automatic pgs_kind_t cmd_kind(input logic [FRAME_BITS-1:0] w);
      if (w[15:8] == CMD_WRITE_HI) begin
         cmd_kind = PGS_CMD_WRITE;
      end else if (w == CMD_READ) begin
         cmd_kind = PGS_CMD_READ;
      end else if (w == CMD_SDN_ENTER || w == CMD_SDN_EXIT) begin
         cmd_kind = PGS_CMD_SDN;
      end else begin
         cmd_kind = PGS_CMD_OTHER;
      end
   endfunction : cmd_kind

   assign pins_a = '{sclk: sclk_pin, cs_n: cs_n_pin, din: din_pin};

   pgs_sync u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .clk_en(clk_en),
      .pins_async(pins_a),
      .pins_sync(pins_s)
   );

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sclk_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else if (clk_en) begin
         sclk_d_r <= pins_s.sclk;
         cs_n_d_r <= pins_s.cs_n;
      end
   end

   // Rising edges only count while selected; in mode 1,1 the idle-high clock
   // gives its leading falling edge first, so that edge is never sampled
   assign sclk_rise = pins_s.sclk && !sclk_d_r && !pins_s.cs_n; // R1 R2 R3
   assign sclk_fall = !pins_s.sclk && sclk_d_r && !pins_s.cs_n && any_clk_r; // R2
   assign cs_fall = !pins_s.cs_n && cs_n_d_r;
   assign cs_rise = pins_s.cs_n && !cs_n_d_r;
   assign len_ok = any_clk_r && (bit_cnt_r == CNT_ZERO); // R4
   assign kind = cmd_kind(rx_r);

   // Counter wraps modulo 16; any_clk_r rules out an empty frame
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bit_cnt_r <= CNT_ZERO;
         any_clk_r <= 1'b0;
      end else if (clk_en) begin
         if (cs_fall) begin
            bit_cnt_r <= CNT_ZERO; // R5
            any_clk_r <= 1'b0; // R5
         end else if (sclk_rise) begin
            bit_cnt_r <= bit_cnt_r + 1'b1; // R4
            any_clk_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rx_r <= RX_RST;
         din_cap_r <= 1'b0;
      end else if (clk_en && sclk_rise) begin
         rx_r <= {rx_r[FRAME_BITS-2:0], pins_s.din}; // R2
         din_cap_r <= pins_s.din;
      end
   end

   // Output chain doubles as the 16-bit daisy-chain delay line
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_r <= TX_RST;
      end else if (clk_en) begin
         if (cs_fall) begin
            tx_r <= read_pend_r ? {READ_PAD, cfg_r.gain, cfg_r.channel} : TX_RST; // R11
         end else if (sclk_fall) begin
            tx_r <= {tx_r[FRAME_BITS-2:0], din_cap_r}; // R2 R11
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         dout_o <= 1'b0;
         dout_oe_n <= 1'b1;
      end else if (clk_en) begin
         dout_oe_n <= pins_s.cs_n; // R7
         if (cs_fall) begin
            dout_o <= 1'b0;
         end else if (sclk_fall) begin
            dout_o <= tx_r[FRAME_BITS-1]; // R2
         end else if (!pins_s.cs_n && !any_clk_r) begin
            dout_o <= tx_r[FRAME_BITS-1]; // R11
         end
      end
   end

   // Read request lives only until the next valid frame commits
   always_ff @(posedge core_clk) begin
      if (srst) begin
         read_pend_r <= 1'b0;
      end else if (clk_en && cs_rise && len_ok) begin // R6
         read_pend_r <= (kind == PGS_CMD_READ); // R11
      end
   end

   // Gain and channel survive shutdown so exit restores them
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cfg_r <= '{shutdown: SDN_RST, gain: GAIN_RST, channel: CHAN_RST}; // R9
      end else if (clk_en && cs_rise && len_ok) begin // R4 R6
         case (kind)
            PGS_CMD_WRITE: begin
               cfg_r.gain <= rx_r[GAIN_POS+:4];
               cfg_r.channel <= rx_r[CHAN_POS+:4];
               cfg_r.shutdown <= 1'b0; // R8
            end
            PGS_CMD_SDN: begin
               cfg_r.shutdown <= (rx_r == CMD_SDN_ENTER); // R8
            end
            default: begin
               cfg_r <= cfg_r; // R10
            end
         endcase
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   sequence s_valid_rise(logic [15:0] c);
      clk_en && cs_rise && len_ok && rx_r == c;
   endsequence

   sequence s_next_select;
      clk_en && cs_fall;
   endsequence

   chk_oe_follows_cs: assert property (clk_en |=> dout_oe_n == $past(pins_s.cs_n)) // R7
      else $error("Output enable does not follow chip select");
   chk_bad_len_hold: assert property (clk_en && cs_rise && !len_ok |=> $stable(cfg_r)) // R4
      else $error("Bad-length frame changed state");
   chk_commit_only_rise: assert property (!(clk_en && cs_rise) |=> $stable(cfg_r)) // R6
      else $error("Config changed outside chip-select rise");
   chk_cnt_restart: assert property (clk_en && cs_fall |=> bit_cnt_r == CNT_ZERO && !any_clk_r) // R5
      else $error("Bit counter not restarted");
   chk_sdn_enter: assert property (s_valid_rise(CMD_SDN_ENTER) |=> cfg_r.shutdown) // R8
      else $error("Shutdown not entered");
   chk_sdn_exit: assert property (s_valid_rise(CMD_SDN_EXIT) |=> !cfg_r.shutdown && $stable(cfg_r.gain)) // R8
      else $error("Shutdown exit wrong");
   chk_write_wakes: assert property (clk_en && cs_rise && len_ok && kind == PGS_CMD_WRITE
      |=> !cfg_r.shutdown && cfg_r.gain == $past(rx_r[7:4]) && cfg_r.channel == $past(rx_r[3:0])) // R8
      else $error("Write did not load config");
   chk_nop_hold: assert property (s_valid_rise(CMD_NOP) |=> $stable(cfg_r)) // R10
      else $error("No-operation changed state");
   chk_reset_clear: assert property (@(posedge core_clk) disable iff (1'b0)
      srst |=> cfg_r.gain == GAIN_RST && cfg_r.channel == CHAN_RST && !cfg_r.shutdown) // R9
      else $error("Reset did not clear config");
   chk_sample_rise: assert property (clk_en && sclk_rise |=> rx_r[0] == $past(pins_s.din)) // R2 R3
      else $error("Input not sampled on rising edge");
   // A new select clears the previous frame's last bit, so that edge is excluded
   chk_dout_on_fall: assert property (!pins_s.cs_n && any_clk_r && !sclk_fall && !cs_fall
      |=> $stable(dout_o)) // R2
      else $error("Output changed away from falling edge");
   chk_read_arm: assert property (s_valid_rise(CMD_READ) |=> read_pend_r) // R11
      else $error("Read request not armed");
   chk_read_load: assert property (s_next_select ##0 read_pend_r
      |=> tx_r == {READ_PAD, cfg_r.gain, cfg_r.channel}) // R11
      else $error("Read data not loaded for next frame");
endmodule : pgs_frame
`default_nettype wire

// ### pgs_sync.sv
package pgs_pkg;
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned CNT_W = 4;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [15:0] CMD_NOP = 16'h1000;
   localparam logic [15:0] CMD_SDN_EXIT = 16'hF100;
   localparam logic [15:0] CMD_SDN_ENTER = 16'hF1F1;
   localparam logic [15:0] CMD_READ = 16'h7A00;
   localparam logic [7:0] CMD_WRITE_HI = 8'h3A;
   localparam int unsigned GAIN_POS = 4;
   localparam int unsigned CHAN_POS = 0;
   localparam logic [3:0] GAIN_RST = 4'h0;
   localparam logic [3:0] CHAN_RST = 4'h0;
   localparam logic SDN_RST = 1'b0;
   localparam logic [7:0] READ_PAD = 8'h00;
   localparam logic [15:0] TX_RST = 16'h0000;
   localparam logic [15:0] RX_RST = 16'h0000;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
   } pgs_pins_t;

   typedef struct packed {
      logic shutdown;
      logic [3:0] gain;
      logic [3:0] channel;
   } pgs_cfg_t;

   typedef enum logic [1:0] {
      PGS_CMD_OTHER,
      PGS_CMD_WRITE,
      PGS_CMD_READ,
      PGS_CMD_SDN
   } pgs_kind_t;
endpackage : pgs_pkg

`timescale 1ns/1ps
`default_nettype none
module pgs_sync
   import pgs_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire pgs_pins_t pins_async,
   output pgs_pins_t pins_sync
);
   pgs_pins_t meta_r;

   // Idle levels: chip select high, data low
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_r <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};
         pins_sync <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};
      end else if (clk_en) begin
         meta_r <= pins_async;
         pins_sync <= meta_r;
      end
   end
endmodule : pgs_sync
`default_nettype wire

// ### pgs_master.sv
`timescale 1ns/1ps
`default_nettype none
module pgs_master (
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   // Clock stands still between frames; idle din sits at its pull-down level
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end
   task automatic xfer(input logic mode, input int nbits, input logic [31:0] data,
                       output logic [31:0] rx);
      rx = 32'h0000_0000;
      sclk = mode;
      #200;
      cs_n = 1'b0;
      #100;
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b0;
         din = data[nbits-1-i];
         #62.5;
         rx = {rx[30:0], dout};
         sclk = 1'b1;
         #62.5;
      end
      sclk = mode;
      #100;
      cs_n = 1'b1;
      din = 1'b0;
      #200;
   endtask : xfer
endmodule : pgs_master
`default_nettype wire

// ### pga_spi_slave_frame_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pga_spi_slave_frame_logic_tb_top;
   import pgs_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic clk_en = 1'b1;
   logic sclk, cs_n, din, dout_o, dout_oe_n;
   logic dout_last = 1'b0;
   pgs_cfg_t cfg_r;
   logic [31:0] rx;
   int num_errors = 0;
   int cmp_count = 0;
   // Released line has no pull, so the master sees the inverse of the last bit
   wire logic dout_line = dout_oe_n ? ~dout_last : dout_o;
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) if (!dout_oe_n) dout_last <= dout_o;
   pgs_frame u_pgs_frame (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .sclk_pin(sclk),
      .cs_n_pin(cs_n), .din_pin(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n), .cfg_r(cfg_r));
   pgs_master u_pgs_master (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_line));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic results;
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   task automatic send(input logic mode, input int n, input logic [31:0] data);
      u_pgs_master.xfer(mode, n, data, rx);
   endtask : send
   function automatic logic [15:0] cfgv(input logic sd, input logic [3:0] g, input logic [3:0] c);
      return {7'h00, sd, g, c};
   endfunction : cfgv
   task automatic t_reset;
      chk(16'(cfg_r), cfgv(SDN_RST, GAIN_RST, CHAN_RST));
      chk(16'(dout_oe_n), 16'h0001);
   endtask : t_reset
   task automatic t_write;
      for (int m = 0; m < 2; m++) begin
         send(m[0], 16, {16'h0000, CMD_WRITE_HI, 4'h3 + m[3:0], 4'h9 - m[3:0]});
         chk(16'(cfg_r), cfgv(1'b0, 4'h3 + m[3:0], 4'h9 - m[3:0]));
      end
   endtask : t_write
   task automatic t_length;
      send(1'b0, 15, {16'h0000, CMD_WRITE_HI, 8'h11});
      chk(16'(cfg_r), cfgv(1'b0, 4'h4, 4'h8));
      send(1'b1, 17, {16'h0000, CMD_WRITE_HI, 8'h22});
      chk(16'(cfg_r), cfgv(1'b0, 4'h4, 4'h8));
      send(1'b0, 0, 32'h0000_0000);
      chk(16'(cfg_r), cfgv(1'b0, 4'h4, 4'h8));
      send(1'b0, 32, {16'hFFFF, CMD_WRITE_HI, 8'h7C});
      chk(16'(cfg_r), cfgv(1'b0, 4'h7, 4'hC));
   endtask : t_length
   task automatic t_sdn;
      send(1'b0, 16, {16'h0000, CMD_SDN_ENTER});
      chk(16'(cfg_r), cfgv(1'b1, 4'h7, 4'hC));
      send(1'b1, 16, {16'h0000, CMD_NOP});
      chk(16'(cfg_r), cfgv(1'b1, 4'h7, 4'hC));
      send(1'b0, 16, {16'h0000, CMD_SDN_EXIT});
      chk(16'(cfg_r), cfgv(1'b0, 4'h7, 4'hC));
      send(1'b0, 16, {16'h0000, CMD_SDN_ENTER});
      send(1'b0, 16, {16'h0000, CMD_WRITE_HI, 8'h21});
      chk(16'(cfg_r), cfgv(1'b0, 4'h2, 4'h1));
   endtask : t_sdn
   task automatic t_read;
      for (int m = 0; m < 2; m++) begin
         send(m[0], 16, {16'h0000, CMD_READ});
         fork
            send(m[0], 32, {CMD_NOP, CMD_NOP});
            begin
               #300;
               chk(16'(dout_oe_n), 16'h0000);
            end
         join
         // First rise sees the register MSB held from select; the register then follows MSB first
         chk(rx[30:15], {READ_PAD, 4'h2, 4'h1});
         chk(16'(dout_oe_n), 16'h0001);
         chk(16'(cfg_r), cfgv(1'b0, 4'h2, 4'h1));
      end
   endtask : t_read
   // A frame sent while the block is frozen must leave no trace
   task automatic t_freeze;
      @(posedge core_clk);
      #1 clk_en = 1'b0;
      send(1'b0, 16, {16'h0000, CMD_WRITE_HI, 8'h5E});
      chk(16'(cfg_r), cfgv(1'b0, 4'h2, 4'h1));
      chk(16'(dout_oe_n), 16'h0001);
      @(posedge core_clk);
      #1 clk_en = 1'b1;
      send(1'b1, 16, {16'h0000, CMD_WRITE_HI, 8'h5E});
      chk(16'(cfg_r), cfgv(1'b0, 4'h5, 4'hE));
   endtask : t_freeze
   initial begin
      repeat (16) @(posedge core_clk);
      #1 srst = 1'b0;
      @(posedge core_clk);
      #1;
      t_reset();
      t_write();
      t_length();
      t_sdn();
      t_read();
      t_freeze();
      results();
   end
   initial begin
      #400000;
      num_errors++;
      results();
   end
endmodule : pga_spi_slave_frame_logic_tb_top
`default_nettype wire
